// File: verilog/emm_defs.svh
// How it works
// [RULE1] App request enters autonomous mode immediately
// [RULE2] Autonomous mode holds until safe state
// [RULE3] Time-slice ticks continue without link
// [RULE4] Readiness flagged while protection is active
// [RULE5] Unchanged timing: resync, ticks keep running
// [RULE6] Unchanged timing: boot straight into cyclic
// [RULE7] Changed timing: refuse boot until released
// [RULE8] Deactivation ignored during emergency mode
// [RULE9] Return to normal needs no power cycle
// [RULE10] Topology scans answered in every state
// [RULE11] Master deactivation clears protective selection
// [RULE12] Master checks downloads for relevance
// [RULE13] Master flags clock or oversampling changes
// [RULE14] Master treats rewiring as timing change
// [RULE15] Supervision runs beside cyclic processing
// [RULE16] Autonomous state readable by software
`ifndef EMM_DEFS_SVH
`define EMM_DEFS_SVH

`define EMM_ADDR_W    8
`define EMM_OFS_CTRL  8'h00
`define EMM_OFS_STAT  8'h04
`define EMM_OFS_PER   8'h08

`define EMM_CTRL_SEL  0
`define EMM_CTRL_TSEN 1

`define EMM_STAT_AUTO 0
`define EMM_STAT_REF  1
`define EMM_STAT_SYNC 2
`define EMM_STAT_PREP 3
`define EMM_STAT_SEL  4

`define EMM_SEL_RST   1'b0
`define EMM_TSEN_RST  1'b0
`define EMM_PER_W     16
`define EMM_PER_RST   16'h00C8

`endif

// File: verilog/emm_pkg.sv
`default_nettype none
package emm_pkg;
  typedef enum logic [1:0] {
    st_normal,
    st_auto,
    st_refuse
  } emm_state_t;
  typedef logic [31:0] emm_word_t;
endpackage : emm_pkg
`default_nettype wire

// File: verilog/emm_ts_if.sv
`timescale 1ns/1ps
`default_nettype none
interface emm_ts_if #(parameter int W = 16);
  logic         run;
  logic [W-1:0] period;
  logic         tick;
  modport gen (input run, input period, output tick);
  modport ctl (output run, output period, input tick);
endinterface : emm_ts_if
`default_nettype wire

// File: verilog/emm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module emm_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Pins in, synchronised out
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
      end else begin
        s1_reg <= din[i];
        s2_reg <= s1_reg;
      end
    end

    // Only the second stage leaves the block
    assign dout[i] = s2_reg;
  end
endmodule : emm_sync
`default_nettype wire

// File: verilog/emm_tsgen.sv
`timescale 1ns/1ps
`default_nettype none
module emm_tsgen #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Control and tick
  emm_ts_if.gen     ts
);
  logic [W-1:0] cnt_reg;

  // Own counter only, so cyclic work is never borrowed from
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      ts.tick <= 1'b0;
    end else if (!ts.run) begin
      cnt_reg <= '0;
      ts.tick <= 1'b0;
    end else if (cnt_reg >= ts.period - W'(1)) begin
      cnt_reg <= '0;
      ts.tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
      ts.tick <= 1'b0;
    end
  end
endmodule : emm_tsgen
`default_nettype wire

// File: verilog/emm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "emm_defs.svh"
module emm_ctrl #(
  parameter int PER_W = `EMM_PER_W
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // Register port
  input  wire logic [`EMM_ADDR_W-1:0] addr,
  input  wire emm_pkg::emm_word_t     wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output var  emm_pkg::emm_word_t     rdata,
  // Local application
  input  wire logic                   app_prot_active,
  input  wire logic                   app_auto_req,
  input  wire logic                   app_safe,
  // Link pins from the master side
  input  wire logic                   lnk_comm_ok,
  input  wire logic                   lnk_timing_same,
  input  wire logic                   lnk_deact_req,
  input  wire logic                   lnk_scan_req,
  // Status and events
  output var  logic                   ts_tick,
  output var  logic                   scan_ack,
  output var  logic                   boot_cyclic,
  output logic                        boot_refused,
  output logic                        auto_active,
  output logic                        auto_ready
);
  import emm_pkg::*;

  emm_state_t       state_reg;
  logic             sel_reg;
  logic             tsen_reg;
  logic [PER_W-1:0] per_reg;
  logic             synced_reg;
  logic             deact_prev_reg;
  logic             scan_prev_reg;
  logic             comm_prev_reg;
  logic [3:0]       lnk_s;
  logic             c_ok;
  logic             t_same;
  logic             deact;
  logic             scan;
  logic             comm_rise;
  logic             deact_rise;
  logic             scan_rise;
  logic             ts_run;

  emm_ts_if #(.W(PER_W)) ts_bus ();

  // Link pins cross from the master's timing
  emm_sync #(.W(4)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({lnk_scan_req, lnk_deact_req,
              lnk_timing_same, lnk_comm_ok}),
    .dout   (lnk_s)
  );

  assign c_ok   = lnk_s[0];
  assign t_same = lnk_s[1];
  assign deact  = lnk_s[2];
  assign scan   = lnk_s[3];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      deact_prev_reg <= 1'b0;
      scan_prev_reg  <= 1'b0;
      comm_prev_reg  <= 1'b0;
    end else begin
      deact_prev_reg <= deact;
      scan_prev_reg  <= scan;
      comm_prev_reg  <= c_ok;
    end
  end

  assign comm_rise  = c_ok & ~comm_prev_reg;
  assign deact_rise = deact & ~deact_prev_reg;
  assign scan_rise  = scan & ~scan_prev_reg;

  // Readiness needs a selected, active protection
  assign auto_ready = sel_reg & app_prot_active; // [RULE4]

  // Mode sequencing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= st_normal;
    end else begin
      unique case (state_reg)
        st_normal: begin
          if (auto_ready && app_auto_req) begin
            state_reg <= st_auto; // [RULE1] [RULE4]
          end
        end
        st_auto: begin
          if (app_safe) begin
            state_reg <= st_normal; // [RULE2] [RULE9]
          end else if (comm_rise && !t_same) begin
            state_reg <= st_refuse; // [RULE7]
          end
        end
        st_refuse: begin
          if (app_safe) begin
            state_reg <= st_normal; // [RULE7] [RULE9]
          end
        end
      endcase
    end
  end

  assign auto_active  = (state_reg != st_normal); // [RULE16]
  assign boot_refused = (state_reg == st_refuse); // [RULE7]

  // Resync keeps the time slices of the emergency
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      synced_reg <= 1'b0;
    end else if (!c_ok) begin
      synced_reg <= 1'b0;
    end else if (comm_rise && (state_reg != st_refuse)
                 && (t_same || state_reg == st_normal)) begin
      synced_reg <= 1'b1; // [RULE5]
    end else if (state_reg == st_refuse && app_safe) begin
      synced_reg <= 1'b1; // [RULE7]
    end
  end

  // Boot pulse: direct boot or delayed restart
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_cyclic <= 1'b0;
    end else begin
      boot_cyclic <= 1'b0;
      if (comm_rise && state_reg == st_normal) begin
        boot_cyclic <= 1'b1; // [RULE6]
      end else if (comm_rise && state_reg == st_auto
                   && t_same) begin
        boot_cyclic <= 1'b1; // [RULE5] [RULE6]
      end else if (state_reg == st_refuse && app_safe
                   && c_ok) begin
        boot_cyclic <= 1'b1; // [RULE7]
      end
    end
  end

  // Scans answered whatever the mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_ack <= 1'b0;
    end else begin
      scan_ack <= scan_rise; // [RULE10]
    end
  end

  // Protective selection; the master's clear loses
  // against nothing but the emergency itself
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= `EMM_SEL_RST;
    end else if (deact_rise && state_reg == st_normal) begin
      sel_reg <= 1'b0; // [RULE11]
    end else if (wr_en && addr == `EMM_OFS_CTRL) begin
      sel_reg <= wdata[`EMM_CTRL_SEL]; // [RULE8]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tsen_reg <= `EMM_TSEN_RST;
    end else if (wr_en && addr == `EMM_OFS_CTRL) begin
      tsen_reg <= wdata[`EMM_CTRL_TSEN];
    end
  end

  // Zero period would wrap the divider limit to all ones, the longest period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_reg <= PER_W'(`EMM_PER_RST);
    end else if (wr_en && addr == `EMM_OFS_PER) begin
      per_reg <= (wdata[PER_W-1:0] == '0) ? PER_W'(1)
                                           : wdata[PER_W-1:0];
    end
  end

  // Emergency forces the slices on, link or not
  assign ts_run = auto_active | (tsen_reg & c_ok); // [RULE3]

  assign ts_bus.run    = ts_run;
  assign ts_bus.period = per_reg;
  assign ts_tick       = ts_bus.tick;

  emm_tsgen #(.W(PER_W)) u_tsgen ( // [RULE15]
    .clk    (clk),
    .arst_n (arst_n),
    .ts     (ts_bus.gen)
  );

  function automatic emm_word_t emm_rd(
    input logic [`EMM_ADDR_W-1:0] a
  );
    emm_word_t v;
    v = '0;
    unique case (a)
      `EMM_OFS_CTRL: begin
        v[`EMM_CTRL_SEL]  = sel_reg;
        v[`EMM_CTRL_TSEN] = tsen_reg;
      end
      `EMM_OFS_STAT: begin
        v[`EMM_STAT_AUTO] = auto_active;
        v[`EMM_STAT_REF]  = boot_refused;
        v[`EMM_STAT_SYNC] = synced_reg;
        v[`EMM_STAT_PREP] = auto_ready;
        v[`EMM_STAT_SEL]  = sel_reg;
      end
      `EMM_OFS_PER: begin
        v[PER_W-1:0] = per_reg;
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction : emm_rd

  // Data stand one cycle only, zero otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= emm_rd(addr); // [RULE16]
    end else begin
      rdata <= '0;
    end
  end

  // Checks
  logic [PER_W:0] gap_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= '0;
    end else if (ts_tick || !ts_run) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= gap_reg + (PER_W+1)'(1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_entry_instant: assert property ( // [RULE1]
    state_reg == st_normal && auto_ready && app_auto_req
    |=> auto_active)
    else $error("autonomous entry delayed");

  a_hold_unsafe: assert property ( // [RULE2]
    auto_active && !app_safe |=> auto_active)
    else $error("autonomous left before safe state");

  a_tick_gap: assert property ( // [RULE3]
    auto_active && $stable(per_reg)
    |-> gap_reg <= {1'b0, per_reg} + (PER_W+1)'(1))
    else $error("time-slice tick missing in emergency");

  a_ready_gate: assert property ( // [RULE4]
    state_reg == st_normal && !auto_ready
    |=> state_reg == st_normal)
    else $error("autonomous entered without readiness");

  a_resync_keep: assert property ( // [RULE5]
    state_reg == st_auto && comm_rise && t_same && !app_safe
    |=> auto_active && ts_run && synced_reg && boot_cyclic)
    else $error("resync dropped time slices");

  a_boot_direct: assert property ( // [RULE6]
    state_reg == st_normal && comm_rise |=> boot_cyclic)
    else $error("no cyclic boot on unchanged timing");

  // Leaving refuse is fine once safe is reported
  a_refuse_boot: assert property ( // [RULE7]
    state_reg == st_auto && comm_rise && !t_same && !app_safe
    |=> boot_refused && !boot_cyclic
    ##1 (boot_refused || $past(app_safe)))
    else $error("changed timing not refused");

  a_deact_ignored: assert property ( // [RULE8]
    auto_active && deact_rise && !wr_en |=> $stable(sel_reg))
    else $error("deactivated during emergency");

  a_back_normal: assert property ( // [RULE9]
    auto_active && app_safe |=> !auto_active ##1 !boot_refused)
    else $error("no return to normal");

  a_scan_answer: assert property ( // [RULE10]
    scan_rise |=> scan_ack ##1 !scan_ack)
    else $error("topology scan not answered");

  a_deact_clears: assert property ( // [RULE11]
    state_reg == st_normal && deact_rise |=> !sel_reg)
    else $error("deactivation did not clear selection");

  a_stat_read: assert property ( // [RULE16]
    rd_en && addr == `EMM_OFS_STAT
    |=> rdata[`EMM_STAT_AUTO] == $past(auto_active))
    else $error("status read wrong autonomous bit");

  a_refuse_hold: assert property ( // [RULE7]
    boot_refused && !app_safe |=> boot_refused && !boot_cyclic)
    else $error("refused boot released early");

  a_refuse_exit: assert property ( // [RULE7]
    boot_refused && app_safe && c_ok
    |=> boot_cyclic && !auto_active)
    else $error("no restart after refusal ended");

  a_same_no_refuse: assert property ( // [RULE6]
    state_reg == st_auto && comm_rise && t_same |=> !boot_refused)
    else $error("boot refused on unchanged timing");

  // Main scenarios seen at least once
  c_entry: cover property (
    state_reg == st_normal ##1 state_reg == st_auto);

  c_refuse: cover property (
    state_reg == st_refuse ##[1:50] state_reg == st_normal);

  c_resync: cover property (
    state_reg == st_auto && comm_rise && t_same);

  c_deact: cover property (
    state_reg == st_auto && deact_rise);

  c_boot_normal: cover property (
    state_reg == st_normal && comm_rise);
endmodule : emm_ctrl
`default_nettype wire

// File: dv/emm_cu_model.sv
`timescale 1ns/1ps
`default_nettype none
module emm_cu_model (
  // Clock
  input  wire logic clk,
  // Link pins toward the component
  output var  logic comm_ok,
  output var  logic timing_same,
  output var  logic deact_req,
  output var  logic scan_req
);
  initial begin
    comm_ok     = 1'b0;
    timing_same = 1'b0;
    deact_req   = 1'b0;
    scan_req    = 1'b0;
  end
  // Three cycles so the two-stage sync always sees a level
  task automatic hold3();
    repeat (3) @(posedge clk);
  endtask : hold3
  // same=0 after clock, oversampling or wiring change
  task automatic resume(input logic same);
    @(posedge clk);
    timing_same <= same;
    comm_ok     <= 1'b1;
    hold3();
  endtask : resume
  task automatic drop();
    @(posedge clk);
    comm_ok <= 1'b0;
    hold3();
  endtask : drop
  task automatic deactivate();
    @(posedge clk);
    deact_req <= 1'b1;
    hold3();
    deact_req <= 1'b0;
    hold3();
  endtask : deactivate
  task automatic scan();
    @(posedge clk);
    scan_req <= 1'b1;
    hold3();
    scan_req <= 1'b0;
    hold3();
  endtask : scan
endmodule : emm_cu_model
`default_nettype wire

// File: dv/autonomous_emergency_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module autonomous_emergency_mode_ctrl_tb;
  import emm_pkg::*;
  logic       clk, arst_n, wr_en, rd_en;
  logic [7:0] addr;
  emm_word_t  wdata, rdata;
  logic       app_prot_active, app_auto_req, app_safe;
  logic       comm_ok, timing_same, deact_req, scan_req;
  logic       ts_tick, scan_ack, boot_cyclic;
  logic       boot_refused, auto_active, auto_ready;
  int         err_count, checks_done, cyc, k, m;
  int         n_tick, n_boot, n_scan, last_tick, tick_gap;

  emm_cu_model cu (.clk(clk), .comm_ok(comm_ok), .timing_same(timing_same),
    .deact_req(deact_req), .scan_req(scan_req));
  emm_ctrl dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .app_prot_active(app_prot_active), .app_auto_req(app_auto_req),
    .app_safe(app_safe), .lnk_comm_ok(comm_ok),
    .lnk_timing_same(timing_same), .lnk_deact_req(deact_req),
    .lnk_scan_req(scan_req), .ts_tick(ts_tick), .scan_ack(scan_ack),
    .boot_cyclic(boot_cyclic), .boot_refused(boot_refused),
    .auto_active(auto_active), .auto_ready(auto_ready));

  always #2.5 clk = ~clk;

  // Pulse counters; a hang is cut short after 5000 cycles
  always @(posedge clk) begin
    cyc++;
    if (ts_tick === 1'b1) begin
      tick_gap  = cyc - last_tick;
      last_tick = cyc;
      n_tick++;
    end
    if (boot_cyclic === 1'b1) n_boot++;
    if (scan_ack === 1'b1) n_scan++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input emm_word_t got, input emm_word_t exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input emm_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input emm_word_t exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc_wait

  task automatic t_reset();
    chk({ts_tick, scan_ack, boot_cyclic, boot_refused, auto_active,
      auto_ready}, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_00C8);
    rd(8'h0C, 32'h0000_0000);
    wr(8'h0C, 32'h0000_FFFF);
    rd(8'h0C, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    rd(8'h08, 32'h0000_0001);
  endtask : t_reset
  task automatic t_ready();
    wr(8'h08, 32'h0000_000A);
    rd(8'h08, 32'h0000_000A);
    wr(8'h00, 32'h0000_0001);
    app_prot_active <= 1'b1;
    cyc_wait(1);
    chk(auto_ready, 1);
    rd(8'h04, 32'h0000_0018);
  endtask : t_ready
  task automatic t_enter();
    k = n_tick;
    @(posedge clk);
    app_auto_req <= 1'b1;
    cyc_wait(1);
    chk(auto_active, 1);
    @(posedge clk);
    app_auto_req <= 1'b0;
    cyc_wait(34);
    chk(n_tick - k, 3);
    chk(tick_gap, 10);
    chk(auto_active, 1);
    rd(8'h04, 32'h0000_0019);
  endtask : t_enter
  task automatic t_link_auto();
    k = n_scan;
    cu.deactivate();
    cu.scan();
    chk(n_scan - k, 1);
    rd(8'h00, 32'h0000_0001);
    chk(auto_active, 1);
  endtask : t_link_auto
  task automatic t_resume_same();
    k = n_boot;
    m = n_tick;
    cu.resume(1'b1);
    cyc_wait(5);
    chk(n_boot - k, 1);
    chk(boot_refused, 0);
    chk(auto_active, 1);
    cyc_wait(20);
    chk(n_tick - m > 1, 1);
    rd(8'h04, 32'h0000_001D);
  endtask : t_resume_same
  task automatic t_leave();
    @(posedge clk);
    app_safe <= 1'b1;
    cyc_wait(1);
    chk(auto_active, 0);
    @(posedge clk);
    app_safe <= 1'b0;
  endtask : t_leave
  task automatic t_changed();
    cu.drop();
    @(posedge clk);
    app_auto_req <= 1'b1;
    @(posedge clk);
    app_auto_req <= 1'b0;
    k = n_boot;
    cu.resume(1'b0);
    cyc_wait(5);
    chk(boot_refused, 1);
    chk(n_boot - k, 0);
    chk(auto_active, 1);
    t_leave();
    chk(boot_refused, 0);
    cyc_wait(2);
    chk(n_boot - k, 1);
  endtask : t_changed
  task automatic t_deact_normal();
    cu.deactivate();
    rd(8'h00, 32'h0000_0000);
    chk(auto_ready, 0);
    k = n_boot;
    cu.drop();
    cu.resume(1'b0);
    cyc_wait(5);
    chk(n_boot - k, 1);
    chk(boot_refused, 0);
    k = n_boot;
    cu.drop();
    cu.resume(1'b1);
    cyc_wait(5);
    chk(n_boot - k, 1);
    rd(8'h04, 32'h0000_0004);
    m = n_tick;
    wr(8'h00, 32'h0000_0002);
    cyc_wait(25);
    chk(n_tick - m > 1, 1);
  endtask : t_deact_normal

  task automatic wrap_up();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {wr_en, rd_en, app_prot_active, app_auto_req, app_safe} = '0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    cyc_wait(1);
    t_reset();
    t_ready();
    t_enter();
    t_link_auto();
    t_resume_same();
    cyc_wait(5);
    chk(auto_active, 1);
    t_leave();
    t_changed();
    t_deact_normal();
    wrap_up();
  end
endmodule : autonomous_emergency_mode_ctrl_tb
`default_nettype wire
